//--- spi_nand_sequencer.sv
// Behaviour
// - Block erase sets all 64 pages of the addressed block to FFh.
// - Erase is accepted only while the write latch flag is 1.
// - Erase launches only if chip select rises right after the last byte.
// - Erase shows busy, serves status reads, then clears busy and write latch.
// - Erase of a protected block is skipped.
// - Loads 02h/84h take a 12-bit column, data, and need the write latch.
// - Bytes past the end of the data buffer are ignored.
// - Full load fills unwritten bytes with FFh; random load keeps them.
// - All 2112 bytes accepted; with ECC on, two status bits report the result.
// - Quad loads 32h/34h take data on four lines.
// - Quad instructions are rejected while quad-disable is 1.
// - Program execute 10h, dummy byte, page address, writes buffer to page.
// - Program runs busy, then clears busy and write latch; protected pages skipped.
// - Page read 13h copies 2112 page bytes into the buffer while busy.
// - Read 03h: column plus 8 dummy or 24 dummy clocks, MSB first on falls.
// - Fast read 0Bh: column plus 8 dummy or 32 dummy clocks.
// - Read runs from column to buffer end, then output floats.
// - Dual fast read 3Bh sends data on two lines.
// - Line 0 carries even bits, line 1 odd bits, bits 7 and 6 first.
// - 06h sets the write latch flag, 04h clears it.
// - Page address bits 5..0 pick the page, upper bits the block.
`timescale 1ns/100ps
`include "spi_nand_defs.svh"

module spi_nand_sequencer #(
  parameter int ERASE_DURATION_NS = 20000,
  parameter int PROGRAM_DURATION_NS = 8000,
  parameter int PAGE_LOAD_DURATION_NS = 4000,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe,
  input wire spi_nand_pkg::protect_t i_protect,
  input wire logic i_quad_disable,
  input wire logic i_continuous_read,
  input wire logic i_ecc_enable,
  output logic o_busy,
  output logic o_write_latch_flag,
  output logic [1:0] o_ecc_status,
  output spi_nand_pkg::arr_cmd_t o_arr_cmd,
  output logic o_arr_wr_valid,
  input wire logic i_arr_wr_ready,
  output logic [7:0] o_arr_wr_data,
  input wire logic i_arr_rd_valid,
  output logic o_arr_rd_ready,
  input wire logic [7:0] i_arr_rd_data,
  input wire logic [1:0] i_arr_ecc_result
);

  localparam logic [23:0] ERASE_CYCLES =
    24'((ERASE_DURATION_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam logic [23:0] PROGRAM_CYCLES =
    24'((PROGRAM_DURATION_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam logic [23:0] PAGE_LOAD_CYCLES =
    24'((PAGE_LOAD_DURATION_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);

  typedef struct packed {
    spi_nand_pkg::phase_t phase;
    logic [7:0] opcode;
    logic [2:0] byte_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] sh;
    logic [15:0] addr;
    logic [11:0] col;
    logic [11:0] start_col;
    logic [2:0] dummy_left;
    logic quad_in;
    logic dual_out;
    logic status_out;
    logic [7:0] out_sh;
    logic [2:0] out_cnt;
    logic [1:0] io_out;
    logic [1:0] io_oe;
    logic write_latch_flag;
    logic busy;
    spi_nand_pkg::arr_op_t op;
    logic [15:0] page;
    logic cmd_valid;
    logic [23:0] timer;
    logic [11:0] xfer;
    logic fill_on;
    logic [11:0] fill_ptr;
    logic [1:0] ecc;
  } core_state_t;

  core_state_t q;
  core_state_t d;
  spi_nand_pkg::pin_sample_t pins;
  logic [7:0] buffer [2112];
  logic wr_en;
  logic [11:0] wr_addr;
  logic [7:0] wr_data;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_empty;

  // Block range covered by the protect bits; top select counts from the high end
  function automatic logic block_protected(input spi_nand_pkg::protect_t p, input logic [9:0] blk);
    logic [10:0] span;
    span = `BLOCK_COUNT >> (3'd7 - p.range);
    if (p.range == 3'd0) begin
      return 1'b0;
    end
    if (p.top_select) begin
      return {1'b0, blk} >= (`BLOCK_COUNT - span);
    end
    return {1'b0, blk} < span;
  endfunction

  function automatic logic is_quad(input logic [7:0] op);
    return (op == `OP_QUAD_LOAD_FULL) || (op == `OP_QUAD_LOAD_RANDOM);
  endfunction

  spi_nand_pin_sync u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_cs_n(i_cs_n),
    .i_sclk(i_sclk),
    .i_io(i_io),
    .o_pins(pins)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Command decoding, buffer access and self-timed operations

  always_comb begin
    logic [7:0] nb;
    logic [3:0] bsum;
    logic [7:0] ob;
    d = q;
    nb = 8'h00;
    bsum = 4'h0;
    ob = 8'h00;
    wr_en = 1'b0;
    wr_addr = 12'h000;
    wr_data = 8'h00;
    fifo_in_valid = 1'b0;
    o_arr_rd_ready = 1'b0;
    d.cmd_valid = 1'b0;

    if (pins.cs_rise) begin
      // chip select must rise exactly on a byte boundary after the address
      if (!q.busy && q.phase == spi_nand_pkg::PH_ADDR && q.bit_cnt == 3'd0 && q.byte_cnt == `ADDR_CMD_BYTES) begin
        d.page = q.addr;
        d.xfer = 12'h000;
        unique case (q.opcode)
          `OP_BLOCK_ERASE: begin
            // needs the latch, skipped on a protected block
            if (q.write_latch_flag && !block_protected(i_protect, q.addr[15:`PAGE_IN_BLOCK_MSB+1])) begin
              // array erases the whole block to the erased value
              d.op = spi_nand_pkg::ARR_ERASE;
              d.busy = 1'b1;
              d.cmd_valid = 1'b1;
              d.timer = ERASE_CYCLES;
              d.xfer = `BUF_BYTES;
            end
          end
          `OP_PROGRAM_EXECUTE: begin
            // buffer goes to the page only with the latch set and its block not protected
            if (q.write_latch_flag && !block_protected(i_protect, q.addr[15:`PAGE_IN_BLOCK_MSB+1])) begin
              d.op = spi_nand_pkg::ARR_PROGRAM;
              d.busy = 1'b1;
              d.cmd_valid = 1'b1;
              d.timer = PROGRAM_CYCLES;
            end
          end
          default: begin
            d.op = spi_nand_pkg::ARR_READ;
            d.busy = 1'b1;
            d.cmd_valid = 1'b1;
            d.timer = PAGE_LOAD_CYCLES;
          end
        endcase
      end
      d.phase = spi_nand_pkg::PH_OPCODE;
      d.byte_cnt = 3'd0;
      d.bit_cnt = 3'd0;
      d.quad_in = 1'b0;
      d.io_oe = 2'b00;
    end else if (pins.cs_n) begin
      d.phase = spi_nand_pkg::PH_OPCODE;
      d.bit_cnt = 3'd0;
      d.byte_cnt = 3'd0;
      d.io_oe = 2'b00;
    end else if (pins.sclk_rise && q.phase != spi_nand_pkg::PH_DOUT && q.phase != spi_nand_pkg::PH_IGNORE) begin
      // quad data is one nibble per clock, high nibble first
      if (q.quad_in) begin
        nb = {q.sh[3:0], pins.io};
        bsum = {1'b0, q.bit_cnt} + 4'd4;
      end else begin
        nb = {q.sh[6:0], pins.io[0]};
        bsum = {1'b0, q.bit_cnt} + 4'd1;
      end
      d.sh = nb;
      d.bit_cnt = bsum[2:0];
      if (bsum[3]) begin
        if (q.byte_cnt != 3'd7) begin
          d.byte_cnt = q.byte_cnt + 3'd1;
        end
        unique case (q.phase)
          spi_nand_pkg::PH_OPCODE: begin
            d.opcode = nb;
            d.phase = spi_nand_pkg::PH_IGNORE;
            d.dual_out = 1'b0;
            d.status_out = 1'b0;
            // a busy device only answers the status read
            if (!q.busy || nb == `OP_STATUS_READ) begin
              unique case (nb)
                `OP_WRITE_ENABLE: d.write_latch_flag = 1'b1;
                `OP_WRITE_DISABLE: d.write_latch_flag = 1'b0;
                `OP_RESET: begin
                  d.write_latch_flag = 1'b0;
                  d.fill_on = 1'b0;
                end
                `OP_STATUS_READ, `OP_BLOCK_ERASE, `OP_PROGRAM_EXECUTE, `OP_PAGE_READ: begin
                  d.phase = spi_nand_pkg::PH_ADDR;
                end
                `OP_LOAD_FULL, `OP_LOAD_RANDOM, `OP_QUAD_LOAD_FULL, `OP_QUAD_LOAD_RANDOM: begin
                  // latch needed, quad refused while disabled
                  if (q.write_latch_flag && !(is_quad(nb) && i_quad_disable)) begin
                    d.phase = spi_nand_pkg::PH_ADDR;
                  end
                end
                `OP_READ, `OP_FAST_READ, `OP_FAST_READ_DUAL: begin
                  d.dual_out = (nb == `OP_FAST_READ_DUAL);
                  // long dummy form starts from column zero
                  if (i_continuous_read) begin
                    d.col = 12'h000;
                    d.phase = spi_nand_pkg::PH_DUMMY;
                    d.dummy_left = (nb == `OP_READ) ? `DUMMY_BYTES_CONT_READ : `DUMMY_BYTES_CONT_FAST;
                  end else begin
                    d.phase = spi_nand_pkg::PH_ADDR;
                  end
                end
                default: d.phase = spi_nand_pkg::PH_IGNORE;
              endcase
            end
          end
          spi_nand_pkg::PH_ADDR: begin
            d.addr = {q.addr[7:0], nb};
            if (q.opcode == `OP_STATUS_READ) begin
              d.status_out = 1'b1;
              d.phase = spi_nand_pkg::PH_DOUT;
              d.out_cnt = 3'd0;
            end else if (q.byte_cnt == 3'd2) begin
              // Only the low twelve column bits are kept
              d.col = {q.addr[3:0], nb};
              d.start_col = {q.addr[3:0], nb};
              unique case (q.opcode)
                `OP_LOAD_FULL, `OP_LOAD_RANDOM, `OP_QUAD_LOAD_FULL, `OP_QUAD_LOAD_RANDOM: begin
                  d.phase = spi_nand_pkg::PH_DIN;
                  d.quad_in = is_quad(q.opcode);
                  // full load sweeps FFh over every byte it does not write
                  if (q.opcode == `OP_LOAD_FULL || q.opcode == `OP_QUAD_LOAD_FULL) begin
                    d.fill_on = 1'b1;
                    d.fill_ptr = 12'h000;
                  end
                end
                `OP_READ, `OP_FAST_READ, `OP_FAST_READ_DUAL: begin
                  d.phase = spi_nand_pkg::PH_DUMMY;
                  d.dummy_left = `DUMMY_BYTES_BUFFER;
                end
                default: d.phase = spi_nand_pkg::PH_ADDR;
              endcase
            end
          end
          spi_nand_pkg::PH_DUMMY: begin
            d.dummy_left = q.dummy_left - 3'd1;
            if (q.dummy_left == 3'd1) begin
              d.phase = spi_nand_pkg::PH_DOUT;
              d.out_cnt = 3'd0;
            end
          end
          default: begin
            // every in-range byte is taken, the excess dropped
            if (q.col < `BUF_BYTES) begin
              wr_en = 1'b1;
              wr_addr = q.col;
              wr_data = nb;
              d.col = q.col + 12'd1;
            end
          end
        endcase
      end
    end else if (pins.sclk_fall && q.phase == spi_nand_pkg::PH_DOUT) begin
      // output changes on falling clock edges, MSB first
      if (q.out_cnt == 3'd0) begin
        if (q.status_out) begin
          ob = {6'h00, q.write_latch_flag, q.busy};
        end else begin
          ob = buffer[q.col];
        end
        // past the buffer end the line floats
        if (!q.status_out && q.col >= `BUF_BYTES) begin
          d.io_oe = 2'b00;
          d.phase = spi_nand_pkg::PH_IGNORE;
        end else begin
          if (!q.status_out) begin
            d.col = q.col + 12'd1;
          end
          d.io_oe = q.dual_out ? 2'b11 : 2'b10;
          // dual sends bit 7 on line 1 and bit 6 on line 0
          d.io_out = q.dual_out ? ob[7:6] : {ob[7], 1'b0};
          d.out_sh = q.dual_out ? {ob[5:0], 2'b00} : {ob[6:0], 1'b0};
          d.out_cnt = q.dual_out ? 3'd2 : 3'd1;
        end
      end else begin
        d.io_out = q.dual_out ? q.out_sh[7:6] : {q.out_sh[7], 1'b0};
        d.out_sh = q.dual_out ? {q.out_sh[5:0], 2'b00} : {q.out_sh[6:0], 1'b0};
        d.out_cnt = q.out_cnt + (q.dual_out ? 3'd2 : 3'd1);
      end
    end

    // Background FFh sweep yields to host writes and skips the bytes already loaded;
    // a full load that restarts it this cycle wins over its step and its end
    if (q.fill_on && !wr_en && d.fill_ptr == q.fill_ptr) begin
      if (q.fill_ptr < q.start_col || q.fill_ptr >= q.col) begin
        wr_en = 1'b1;
        wr_addr = q.fill_ptr;
        wr_data = `ERASED_BYTE;
      end
      d.fill_ptr = q.fill_ptr + 12'd1;
      if (q.fill_ptr == `BUF_LAST) begin
        d.fill_on = 1'b0;
      end
    end

    // Array transfers wait for the sweep so it cannot clobber them
    if (q.busy) begin
      if (q.timer != 24'h000000) begin
        d.timer = q.timer - 24'h000001;
      end
      if (!q.fill_on && q.xfer < `BUF_BYTES) begin
        if (q.op == spi_nand_pkg::ARR_PROGRAM) begin
          fifo_in_valid = 1'b1;
          if (fifo_in_ready) begin
            d.xfer = q.xfer + 12'd1;
          end
        end else if (q.op == spi_nand_pkg::ARR_READ && !wr_en) begin
          o_arr_rd_ready = 1'b1;
          if (i_arr_rd_valid) begin
            wr_en = 1'b1;
            wr_addr = q.xfer;
            wr_data = i_arr_rd_data;
            d.xfer = q.xfer + 12'd1;
          end
        end
      end
      if (q.timer == 24'h000000 && q.xfer == `BUF_BYTES && fifo_empty) begin
        d.busy = 1'b0;
        // erase and program drop the write latch on completion
        if (q.op != spi_nand_pkg::ARR_READ) begin
          d.write_latch_flag = 1'b0;
        end else begin
          d.ecc = i_arr_ecc_result;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '{phase: spi_nand_pkg::PH_OPCODE, op: spi_nand_pkg::ARR_READ, default: '0};
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      buffer[wr_addr] <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Program data path to the array, stalled by the array's ready

  spi_nand_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(buffer[q.xfer]),
    .o_out_valid(o_arr_wr_valid),
    .i_out_ready(i_arr_wr_ready),
    .o_out_data(o_arr_wr_data),
    .o_empty(fifo_empty)
  );

  assign o_io_out = {2'b00, q.io_out};
  assign o_io_oe = {2'b00, q.io_oe};
  assign o_busy = q.busy;
  assign o_write_latch_flag = q.write_latch_flag;
  // result bits only report while ECC is enabled
  assign o_ecc_status = i_ecc_enable ? q.ecc : 2'b00;
  assign o_arr_cmd.valid = q.cmd_valid;
  assign o_arr_cmd.op = q.op;
  assign o_arr_cmd.page = q.page;

endmodule

//--- spi_nand_defs.svh
`ifndef SPI_NAND_DEFS_SVH
`define SPI_NAND_DEFS_SVH

// Opcodes
`define OP_RESET 8'hff
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ 8'h0f
`define OP_BLOCK_ERASE 8'hd8
`define OP_LOAD_FULL 8'h02
`define OP_LOAD_RANDOM 8'h84
`define OP_QUAD_LOAD_FULL 8'h32
`define OP_QUAD_LOAD_RANDOM 8'h34
`define OP_PROGRAM_EXECUTE 8'h10
`define OP_PAGE_READ 8'h13
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_FAST_READ_DUAL 8'h3b

// Buffer and array geometry
`define BUF_BYTES 12'd2112
`define BUF_LAST 12'd2111
`define ERASED_BYTE 8'hff
`define BLOCK_COUNT 11'd1024
`define PAGE_IN_BLOCK_MSB 5
`define ADDR_CMD_BYTES 3'd4

// Dummy bytes after the column, or in place of it in continuous mode
`define DUMMY_BYTES_BUFFER 3'd1
`define DUMMY_BYTES_CONT_READ 3'd3
`define DUMMY_BYTES_CONT_FAST 3'd4

// Clock period in ns at 250 MHz
`define CLK_PERIOD_NS 4

// Reset levels of the synchronisers
`define CS_IDLE 1'b1
`define SCLK_IDLE 1'b0

`endif

//--- spi_nand_pkg.sv
package spi_nand_pkg;

  typedef enum logic [1:0] {ARR_ERASE, ARR_PROGRAM, ARR_READ} arr_op_t;

  typedef struct packed {
    logic valid;
    arr_op_t op;
    logic [15:0] page;
  } arr_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic [3:0] io;
  } pin_sample_t;

  typedef struct packed {
    logic top_select;
    logic [2:0] range;
  } protect_t;

  typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_IGNORE} phase_t;

endpackage

//--- spi_nand_pin_sync.sv
`timescale 1ns/100ps
`include "spi_nand_defs.svh"

module spi_nand_pin_sync (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_io,
  output spi_nand_pkg::pin_sample_t o_pins
);

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic sclk_prev;
    logic cs_prev;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d = q;
    d.s1 = {i_cs_n, i_sclk, i_io};
    d.s2 = q.s1;
    d.sclk_prev = q.s2[4];
    d.cs_prev = q.s2[5];
  end

  // Edges are taken from the second stage only
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '{s1: {`CS_IDLE, `SCLK_IDLE, 4'h0}, s2: {`CS_IDLE, `SCLK_IDLE, 4'h0},
             sclk_prev: `SCLK_IDLE, cs_prev: `CS_IDLE};
    end else begin
      q <= d;
    end
  end

  assign o_pins.cs_n = q.s2[5];
  assign o_pins.cs_rise = q.s2[5] & ~q.cs_prev;
  assign o_pins.sclk_rise = q.s2[4] & ~q.sclk_prev;
  assign o_pins.sclk_fall = ~q.s2[4] & q.sclk_prev;
  assign o_pins.io = q.s2[3:0];

endmodule

//--- spi_nand_fifo.sv
`timescale 1ns/100ps

module spi_nand_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic o_empty
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic push;
  logic pop;

  assign full = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
  assign o_empty = (q.wr == q.rd);
  assign o_in_ready = ~full;
  assign o_out_valid = ~o_empty;
  assign o_out_data = mem[q.rd[AW-1:0]];
  assign push = i_in_valid & ~full;
  assign pop = i_out_ready & ~o_empty;

  always_comb begin
    d = q;
    if (push) begin
      d.wr = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[q.wr[AW-1:0]] <= i_in_data;
    end
  end

endmodule

//--- spi_nand_sequencer_monitor.sv
`timescale 1ns/100ps

module spi_nand_sequencer_monitor (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic i_ecc_enable,
  input wire logic [3:0] o_io_out,
  input wire logic [3:0] o_io_oe,
  input wire logic o_busy,
  input wire logic o_write_latch_flag,
  input wire logic [1:0] o_ecc_status,
  input wire spi_nand_pkg::arr_cmd_t o_arr_cmd,
  input wire logic o_arr_rd_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////
  sequence s_busy_hold;
    o_busy [*8];
  endsequence
  sequence s_launch;
    o_arr_cmd.valid ##1 !o_arr_cmd.valid;
  endsequence
  a_busy_holds: assert property ($rose(o_busy) |-> s_busy_hold)
    else $error("busy dropped early");
  a_cmd_pulse: assert property (o_arr_cmd.valid |-> s_launch)
    else $error("launch pulse too long");
  a_launch_busy: assert property (o_arr_cmd.valid |-> ##[0:1] o_busy)
    else $error("launch without busy");
  a_launch_latch: assert property (o_arr_cmd.valid && o_arr_cmd.op != spi_nand_pkg::ARR_READ |-> $past(o_write_latch_flag))
    else $error("write launch without latch");
  a_latch_clears: assert property ($fell(o_busy) && o_arr_cmd.op != spi_nand_pkg::ARR_READ |-> ##[0:1] !o_write_latch_flag)
    else $error("latch kept after operation");
  a_busy_ignores: assert property (o_busy && $past(o_busy) |-> !$rose(o_write_latch_flag))
    else $error("latch set while busy");
  a_ecc_gated: assert property (!i_ecc_enable |-> o_ecc_status == 2'h0)
    else $error("ecc status shown while disabled");
  a_oe_idle: assert property (i_cs_n [*6] |-> o_io_oe == 4'h0)
    else $error("output driven while deselected");
  a_upper_lines: assert property (o_io_oe[3:2] == 2'h0 && o_io_out[3:2] == 2'h0)
    else $error("upper lines driven");
  a_rd_in_busy: assert property (o_arr_rd_ready |-> o_busy)
    else $error("page fetch outside busy");
endmodule

bind spi_nand_sequencer spi_nand_sequencer_monitor u_monitor (.i_clk, .i_reset_n, .i_cs_n, .i_ecc_enable, .o_io_out,
  .o_io_oe, .o_busy, .o_write_latch_flag, .o_ecc_status, .o_arr_cmd, .o_arr_rd_ready);

//--- spi_nand_host_model.sv
`timescale 1ns/100ps

module spi_nand_host_model (
  input wire logic i_clk,
  input wire logic [3:0] i_io,
  output logic o_cs_n,
  output logic o_sclk,
  output logic [3:0] o_io
);
  logic [3:0] got;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_io = 4'h0;
  end
  // Data set before rise, sampled before rise
  task automatic tick(input logic [3:0] v);
    o_io <= v;
    repeat (8) @(posedge i_clk);
    got = i_io;
    o_sclk <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_sclk <= 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b, input logic quad);
    if (quad) begin
      tick(b[7:4]);
      tick(b[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) tick({3'h0, b[i]});
    end
  endtask
  task automatic recv_byte(output logic [7:0] b, input logic dual);
    for (int i = 7; i >= 0; i--) begin
      tick(4'h0);
      b[i] = got[1];
      if (dual) begin
        i--;
        b[i] = got[0];
      end
    end
  endtask
  task automatic open_frame;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask
  // Select rises after last bit; released line flips
  task automatic close_frame;
    repeat (8) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_io <= ~o_io;
    repeat (16) @(posedge i_clk);
  endtask
endmodule

//--- spi_nand_sequencer_tb.sv
`timescale 1ns/100ps
`include "spi_nand_defs.svh"

module spi_nand_sequencer_tb;
  logic i_clk, i_reset_n, quad_dis, cont_rd, ecc_en, wr_ready, busy, write_latch_flag, wr_valid, rd_ready, cs_n, sclk, rd_valid;
  logic [3:0] host_io, io_out, io_oe, io_wire;
  logic [1:0] ecc_st;
  logic [7:0] wr_data, b;
  logic [11:0] wr_cnt = '0, rd_cnt = '0;
  logic [31:0] cyc = '0;
  spi_nand_pkg::protect_t prot;
  spi_nand_pkg::arr_cmd_t acmd, cmd_last;
  logic [7:0] wr_buf [0:2111];
  int num_errors, samples_checked, cmd_cnt = 0;
  assign io_wire = (io_oe & io_out) | (~io_oe & host_io);
  spi_nand_host_model u_host (.i_clk, .i_io(io_wire), .o_cs_n(cs_n), .o_sclk(sclk), .o_io(host_io));
  spi_nand_sequencer #(.ERASE_DURATION_NS(8000), .PROGRAM_DURATION_NS(160), .PAGE_LOAD_DURATION_NS(160)) u_dut (
    .i_clk, .i_reset_n, .i_cs_n(cs_n), .i_sclk(sclk), .i_io(io_wire), .o_io_out(io_out), .o_io_oe(io_oe),
    .i_protect(prot), .i_quad_disable(quad_dis), .i_continuous_read(cont_rd), .i_ecc_enable(ecc_en), .o_busy(busy),
    .o_write_latch_flag(write_latch_flag), .o_ecc_status(ecc_st), .o_arr_cmd(acmd), .o_arr_wr_valid(wr_valid),
    .i_arr_wr_ready(wr_ready), .o_arr_wr_data(wr_data), .i_arr_rd_valid(rd_valid), .o_arr_rd_ready(rd_ready),
    .i_arr_rd_data(rd_cnt[7:0]), .i_arr_ecc_result(2'h2));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////
  // Array side stalls 64 of every 128 cycles so the FIFO fills
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    wr_ready <= cyc[6];
    rd_valid <= cyc[2];
    if (wr_valid && wr_ready) begin
      wr_buf[wr_cnt] <= wr_data;
      wr_cnt <= wr_cnt + 1;
    end
    if (rd_ready && rd_valid) rd_cnt <= rd_cnt + 1;
    if (acmd.valid) begin
      cmd_cnt <= cmd_cnt + 1;
      cmd_last <= acmd;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmd(input logic [31:0] w, input int n, input logic extra);
    u_host.open_frame();
    for (int i = 0; i < n; i++) u_host.send_byte(w[31-8*i -: 8], 1'b0);
    if (extra) u_host.tick(4'h0);
    u_host.close_frame();
  endtask
  task automatic load(input logic [7:0] op, input logic [11:0] col, input logic [7:0] d, input logic quad);
    u_host.open_frame();
    u_host.send_byte(op, 1'b0);
    u_host.send_byte({4'h0, col[11:8]}, 1'b0);
    u_host.send_byte(col[7:0], 1'b0);
    u_host.send_byte(d, quad);
    u_host.close_frame();
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 20000) begin
      num_errors++;
      $display("CHECK FAILED busy wait expected 0 seen 1");
      end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    int c0;
    logic [11:0] cols [5];
    logic [7:0] ops [5];
    cols = '{12'd2110, 12'h123, 12'h0a5, 12'h000, 12'h000};
    ops = '{`OP_READ, `OP_FAST_READ, `OP_FAST_READ_DUAL, `OP_READ, `OP_FAST_READ};
    {i_reset_n, quad_dis, cont_rd, ecc_en, prot} = '0;
    {num_errors, samples_checked} = '0;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    cmd({`OP_WRITE_ENABLE, 24'h0}, 1, 0);
    check("latch set", write_latch_flag, 1);
    cmd({`OP_WRITE_DISABLE, 24'h0}, 1, 0);
    check("latch clear", write_latch_flag, 0);
    c0 = cmd_cnt;
    cmd({`OP_BLOCK_ERASE, 24'h000040}, 4, 0);
    check("erase no latch", busy, 0);
    cmd({`OP_WRITE_ENABLE, 24'h0}, 1, 0);
    prot <= '{1'b0, 3'h7};
    cmd({`OP_BLOCK_ERASE, 24'h000040}, 4, 0);
    check("erase protected", busy, 0);
    prot <= '0;
    cmd({`OP_BLOCK_ERASE, 24'h000040}, 4, 1);
    check("erase extra bit", cmd_cnt - c0, 0);
    cmd({`OP_BLOCK_ERASE, 24'h000040}, 4, 0);
    check("erase cmd", cmd_last, {1'b1, spi_nand_pkg::ARR_ERASE, 16'h0040});
    cmd({`OP_WRITE_DISABLE, 24'h0}, 1, 0);
    check("busy ignores", write_latch_flag, 1);
    u_host.open_frame();
    u_host.send_byte(`OP_STATUS_READ, 1'b0);
    u_host.send_byte(8'hc0, 1'b0);
    u_host.recv_byte(b, 1'b0);
    u_host.close_frame();
    check("status in erase", b, 8'h03);
    wait_idle();
    check("erase latch", write_latch_flag, 0);
    $display("erase tests done");
    cmd({`OP_WRITE_ENABLE, 24'h0}, 1, 0);
    quad_dis <= 1'b1;
    load(`OP_LOAD_FULL, 12'h000, 8'h11, 1'b0);
    repeat (2200) @(posedge i_clk);
    load(`OP_LOAD_RANDOM, 12'h005, 8'ha5, 1'b0);
    load(`OP_QUAD_LOAD_RANDOM, 12'h008, 8'h3c, 1'b1);
    quad_dis <= 1'b0;
    load(`OP_QUAD_LOAD_RANDOM, 12'h007, 8'h5a, 1'b1);
    cmd({`OP_PROGRAM_EXECUTE, 24'h000002}, 4, 0);
    check("program cmd", cmd_last, {1'b1, spi_nand_pkg::ARR_PROGRAM, 16'h0002});
    wait_idle();
    check("program count", wr_cnt, 12'd2112);
    check("program latch", write_latch_flag, 0);
    for (int k = 0; k < 2112; k++) check("program byte", wr_buf[k], k == 0 ? 8'h11 : k == 5 ? 8'ha5 : k == 7 ? 8'h5a : 8'hff);
    $display("program tests done");
    ecc_en <= 1'b1;
    cmd({`OP_PAGE_READ, 24'h000003}, 4, 0);
    check("page read busy", busy, 1);
    wait_idle();
    check("page read count", rd_cnt, 12'd2112);
    check("page read cmd", cmd_last, {1'b1, spi_nand_pkg::ARR_READ, 16'h0003});
    check("ecc on", ecc_st, 2'h2);
    ecc_en <= 1'b0;
    @(posedge i_clk);
    check("ecc off", ecc_st, 2'h0);
    $display("page read tests done");
    for (int t = 0; t < 5; t++) begin
      cont_rd <= (t >= 3);
      u_host.open_frame();
      u_host.send_byte(ops[t], 1'b0);
      u_host.send_byte(t >= 3 ? 8'h00 : {4'h0, cols[t][11:8]}, 1'b0);
      u_host.send_byte(t >= 3 ? 8'h00 : cols[t][7:0], 1'b0);
      u_host.send_byte(8'h00, 1'b0);
      if (t == 4) u_host.send_byte(8'h00, 1'b0);
      for (int k = 0; k < 2; k++) begin
        u_host.recv_byte(b, t == 2);
        check("read data", b, 8'(cols[t] + 12'(k)));
      end
      repeat (8) @(posedge i_clk);
      check("read lines", io_oe, t == 0 ? 4'h0 : t == 2 ? 4'h3 : 4'h2);
      u_host.close_frame();
    end
    $display("buffer read tests done");
    end_of_test();
  end
endmodule
